// File: logic/wgt_pkg.sv
// Package for the windowed guard timer: keys, widths, reset values and carriers.
// Assumes a single system clock domain; the guard tick clock is sampled as a plain input.
package wgt_pkg;

    localparam int          WGT_CNT_W      = 24;           // Width of the down counter.
    localparam int          WGT_PRESCALE   = 4;            // Guard ticks per counter step.
    localparam logic [23:0] WGT_TC_MIN     = 24'h0000ff;   // Smallest reload, 256 steps.
    localparam logic [23:0] WGT_TC_RST     = 24'hffffff;   // Time-out value after reset.
    localparam logic [23:0] WGT_WIN_RST    = 24'hffffff;   // Window open wide after reset.
    localparam logic [23:0] WGT_WARN_RST   = 24'h000000;   // Warning point after reset.
    localparam logic [23:0] WGT_CNT_ZERO   = 24'h000000;   // Counter expiry value.
    localparam logic [7:0]  WGT_FEED_KEY1  = 8'haa;        // First feed key.
    localparam logic [7:0]  WGT_FEED_KEY2  = 8'h55;        // Second feed key.

    // Feed sequence states, one-hot.
    typedef enum logic [1:0] {
        WGT_FEED_IDLE  = 2'b01,
        WGT_FEED_ARMED = 2'b10
    } wgt_feed_t;

    // Software configuration levels.
    typedef struct packed {
        logic        reset_en;   // Fault resets the chip.
        logic        int_en;     // Fault raises the interrupt when reset is off.
        logic        warn_en;    // Warning interrupt enable.
        logic [23:0] timeout;    // Reload value.
        logic [23:0] window;     // Feed allowed only at or below this count.
        logic [23:0] warn;       // Warning point.
    } wgt_cfg_t;

    // Status seen by software.
    typedef struct packed {
        logic        enabled;    // Watchdog running.
        logic        tout_flag;  // Time-out or violation raised an interrupt.
        logic        warn_flag;  // Warning point reached.
        logic        wdrst_flag; // Last reset came from the watchdog.
        logic [23:0] count;      // Live counter.
    } wgt_stat_t;

endpackage

// File: logic/wgt_prescaler.sv
// Guard tick synchroniser and fixed prescaler.
// Assumes guard_tick_clock is slow against mclk (at least four mclk periods per half cycle).
`timescale 1ns/1ps
module wgt_prescaler
    import wgt_pkg::*;
#(
    parameter int DIV = WGT_PRESCALE
) (
    input  wire logic mclk,             // System clock.
    input  wire logic resetn,           // Asynchronous reset, active low.
    input  wire logic guard_tick_clock, // Raw guard oscillator clock.
    input  wire logic clear,            // Restart the prescaler phase.
    output logic      step              // One-cycle pulse every DIV guard ticks.
);

    initial begin
        if (DIV < 2 || DIV > 256) $error("wgt_prescaler: DIV out of range");
    end

    logic       sync1_r;
    logic       sync2_r;
    logic       prev_r;
    logic [7:0] div_r;
    wire        rise     = sync2_r & ~prev_r;
    wire        last_div = (div_r == 8'(DIV - 1));

    // Two-flop synchroniser, then an edge history flop.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= guard_tick_clock;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Divide the guard edges down to counter steps.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_r <= 8'h00;
        end else if (clear) begin
            div_r <= 8'h00;
        end else if (rise) begin
            div_r <= last_div ? 8'h00 : div_r + 8'h01;
        end
    end

    assign step = rise & last_div;

endmodule

// File: logic/wgt_windowed_guard_timer.sv
// Windowed guard timer: down counter, window check, warning, feed sequence, fault handling.
// Assumes resetn is the chip reset that chip_reset_req drives, and porn is power-on only.
`timescale 1ns/1ps
module wgt_windowed_guard_timer
    import wgt_pkg::*;
#(
    parameter int CNT_W = WGT_CNT_W
) (
    input  wire logic      mclk,             // System clock, 100 MHz.
    input  wire logic      resetn,           // Chip reset, asynchronous, active low.
    input  wire logic      porn,             // Power-on reset, asynchronous, active low.
    input  wire logic      guard_tick_clock, // Dedicated guard oscillator clock.
    input  wire wgt_cfg_t  cfg,              // Configuration levels.
    input  wire logic      enable_set,       // Pulse: start the watchdog.
    input  wire logic      feed_wr,          // Pulse: write to the feed location.
    input  wire logic [7:0] feed_data,       // Feed write data.
    input  wire logic      other_access,     // Pulse: any other register access.
    input  wire logic      tout_clr,         // Pulse: clear time-out flag.
    input  wire logic      warn_clr,         // Pulse: clear warning flag.
    input  wire logic      wdrst_clr,        // Pulse: clear watchdog reset flag.
    output wgt_stat_t      stat,             // Status, from registers.
    output logic           irq,              // Interrupt level.
    output logic           chip_reset_req    // Chip reset request, held until resetn.
);

    initial begin
        if (CNT_W != 24) $error("wgt_windowed_guard_timer: CNT_W must be 24");
    end

    logic        en_r;
    logic [23:0] cnt_r;
    logic        tout_r;
    logic        warn_r;
    logic        wdrst_r;
    logic        rst_req_r;
    wgt_feed_t   feed_r;
    wgt_feed_t   feed_nxt;
    logic        step;
    logic        feed_ok;
    logic        seq_bad;

    // Counter steps come from the synchronised, prescaled guard clock.
    // Restarting the prescaler on a feed gives every reload a full first step.
    wgt_prescaler #(
        .DIV(WGT_PRESCALE)
    ) u_pre (
        .mclk             (mclk),
        .resetn           (resetn),
        .guard_tick_clock (guard_tick_clock),
        .clear            (feed_ok | enable_set),
        .step             (step)
    );

    // Feed sequence decode; wrong key or stray access while armed is a bad sequence.
    // A second key one while armed also breaks the pair, so a retry must start from idle.
    wire key1      = feed_wr & (feed_data == WGT_FEED_KEY1);
    wire key2      = feed_wr & (feed_data == WGT_FEED_KEY2);
    wire in_armed  = (feed_r == WGT_FEED_ARMED);

    always_comb begin
        feed_nxt = feed_r;
        feed_ok  = 1'b0;
        seq_bad  = 1'b0;
        case (feed_r)
            WGT_FEED_IDLE: begin
                if (key1) feed_nxt = WGT_FEED_ARMED;
                else if (feed_wr) seq_bad = 1'b1;
            end
            WGT_FEED_ARMED: begin
                feed_nxt = WGT_FEED_IDLE;
                if (key2 && !other_access) feed_ok = 1'b1;
                else if (feed_wr || other_access) seq_bad = 1'b1;
                else feed_nxt = WGT_FEED_ARMED;
            end
            default: feed_nxt = WGT_FEED_IDLE;
        endcase
    end

    // Reload value clamped to the shortest legal time-out.
    // The window compare uses the count before any step that falls in the same cycle.
    wire [23:0] reload    = (cfg.timeout < WGT_TC_MIN) ? WGT_TC_MIN : cfg.timeout;
    wire        win_bad   = feed_ok & (cnt_r > cfg.window);
    wire        reload_ok = feed_ok & ~win_bad;
    wire        expire    = en_r & step & (cnt_r == WGT_CNT_ZERO) & ~reload_ok;
    wire        violation = en_r & (seq_bad | win_bad);
    wire        fault     = expire | violation;
    wire        do_reset  = fault & cfg.reset_en;
    wire        do_int    = fault & ~cfg.reset_en & cfg.int_en;
    wire        warn_hit  = en_r & cfg.warn_en & step & ~reload_ok & (cnt_r == cfg.warn + 24'h000001);

    // Enable: set by software, cleared only by reset or a watchdog reset or interrupt.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) en_r <= 1'b0;
        else if (do_reset || do_int) en_r <= 1'b0;
        else if (enable_set) en_r <= 1'b1;
    end

    // Down counter with reload on a good feed, enable or any expiry, with or without fault action.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) cnt_r <= WGT_TC_RST;
        else if (reload_ok || enable_set || expire) cnt_r <= reload;
        else if (en_r && step) cnt_r <= cnt_r - 24'h000001;
    end

    // Feed state, sticky flags and the held reset request; set wins over clear.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            feed_r    <= WGT_FEED_IDLE;
            tout_r    <= 1'b0;
            warn_r    <= 1'b0;
            rst_req_r <= 1'b0;
        end else begin
            feed_r    <= feed_nxt;
            tout_r    <= do_int | (tout_r & ~tout_clr);
            warn_r    <= warn_hit | (warn_r & ~warn_clr);
            rst_req_r <= rst_req_r | do_reset;
        end
    end

    // Watchdog reset flag lives on power-on reset only so it outlasts the chip reset.
    // A clear and a new watchdog reset in one cycle leave the flag set.
    always_ff @(posedge mclk or negedge porn) begin
        if (!porn) wdrst_r <= 1'b0;
        else wdrst_r <= do_reset | (wdrst_r & ~wdrst_clr);
    end

    // Status straight from the flops; irq gates the time-out and warning flags with their enables.
    assign stat.enabled    = en_r;
    assign stat.tout_flag  = tout_r;
    assign stat.warn_flag  = warn_r;
    assign stat.wdrst_flag = wdrst_r;
    assign stat.count      = cnt_r;
    assign irq             = (tout_r & cfg.int_en) | (warn_r & cfg.warn_en);
    assign chip_reset_req  = rst_req_r;

    // Assertions watch the flops and decodes above on the system clock; all are off while resetn is low.
    // The step spacing check relies on the guard clock being slow, at least four mclk per half period.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_expire_resets: assert property (expire && cfg.reset_en |=> chip_reset_req && wdrst_r)
        else $error("expiry with reset enabled did not request reset");
    // A reset request stays up until the chip reset takes it down.
    a_reset_held: assert property (chip_reset_req |=> chip_reset_req)
        else $error("reset request dropped early");
    // A feed above the window leaves the count alone: it may only hold or step down.
    a_window_reject: assert property (feed_ok && cnt_r > cfg.window && !enable_set
        |=> cnt_r == $past(cnt_r) || cnt_r == $past(cnt_r) - 24'h000001)
        else $error("feed above window reloaded the counter");
    // A feed inside the window loads the clamped reload value.
    a_window_take: assert property (reload_ok |=> cnt_r == $past(reload))
        else $error("feed inside window did not reload");
    a_warn_sets: assert property (warn_hit |=> warn_r && irq)
        else $error("warning point did not raise warning");
    // The warning flag never rises while the warning is off.
    a_warn_off: assert property (!cfg.warn_en |=> !$rose(warn_r))
        else $error("warning rose while disabled");
    // A warning clear with no new hit drops the flag.
    a_warn_clear: assert property (warn_clr && !warn_hit |=> !warn_r)
        else $error("warning flag not cleared");
    a_enable_sticky: assert property (en_r && !$past(do_reset) && !do_reset && !do_int |=> en_r)
        else $error("enable dropped without fault");
    // Starting the watchdog sets the enable and reloads the count.
    a_enable_start: assert property (enable_set && !do_reset && !do_int
        |=> en_r && cnt_r == $past(reload))
        else $error("enable did not start the watchdog");
    a_bad_seq_int: assert property (en_r && seq_bad && !cfg.reset_en && cfg.int_en |=> tout_r && !en_r)
        else $error("bad feed sequence did not interrupt");
    // With reset on, a bad sequence requests the chip reset and stops the watchdog.
    a_seq_reset: assert property (en_r && seq_bad && cfg.reset_en |=> chip_reset_req && !en_r)
        else $error("bad feed sequence did not request reset");
    // An interrupt action never turns into a reset request.
    a_int_no_reset: assert property (do_int && !chip_reset_req |=> tout_r && !chip_reset_req)
        else $error("interrupt action requested a reset");
    // A time-out clear with no new fault drops the flag.
    a_tout_clear: assert property (tout_clr && !do_int |=> !tout_r)
        else $error("time-out flag not cleared");
    // Every watchdog reset leaves its mark in the flag.
    a_wdrst_sets: assert property (do_reset |=> wdrst_r && chip_reset_req)
        else $error("watchdog reset did not set its flag");
    a_flag_holds: assert property (wdrst_r && !wdrst_clr |=> wdrst_r)
        else $error("watchdog reset flag lost");
    // Software clears the watchdog reset flag when no new reset comes with the clear.
    a_wdrst_clear: assert property (wdrst_clr && !do_reset |=> !wdrst_r)
        else $error("watchdog reset flag not cleared");
    a_count_steps: assert property (en_r && step && !reload_ok && !enable_set && cnt_r != WGT_CNT_ZERO
        |=> cnt_r == $past(cnt_r) - 24'h000001)
        else $error("counter did not step down");
    // Four guard ticks of at least eight system cycles each separate two steps.
    a_step_spacing: assert property (step |=> !step [*8])
        else $error("counter steps too close together");
    a_reload_min: assert property (reload_ok |=> cnt_r >= WGT_TC_MIN)
        else $error("reload below minimum");
    // Key one from idle arms the feed.
    a_key_arms: assert property (key1 && !in_armed |=> in_armed)
        else $error("key one did not arm the feed");
    // A feed is only taken as the second half of a pair, idle cycles between the keys allowed.
    a_feed_pair: assert property (feed_ok |-> in_armed && !other_access && $past(in_armed || key1))
        else $error("feed accepted without key one first");
    // A stray access between the keys is a bad sequence.
    a_stray_breaks: assert property (in_armed && other_access && en_r && !cfg.reset_en && cfg.int_en
        |=> tout_r && !en_r)
        else $error("stray access did not break the feed");

    // Covers mark the main scenarios: good feed, reset, warning, refused window and bad sequence.
    c_feed: cover property (reload_ok && en_r);
    c_reset: cover property (do_reset);
    c_warn: cover property (warn_hit);
    c_window: cover property (win_bad && en_r);
    c_bad_seq: cover property (seq_bad && en_r);

endmodule

// File: verif/tb.sv
// Self-checking bench for the windowed guard timer: reset, expiry, feeds, bad sequences, window, warning.
// Assumes the design files under logic/ are compiled first and that the assertions live inside them.
`timescale 1ns/1ps
module tb;
    import wgt_pkg::*;

    logic        mclk;
    logic        resetn;
    logic        porn;
    logic        gclk;
    wgt_cfg_t    cfg;
    logic [4:0]  pls;        // Pulses: 0 enable, 1 other access, 2 tout clear, 3 warn clear, 4 wdrst clear.
    logic        feed_wr;
    logic [7:0]  feed_data;
    wgt_stat_t   stat;
    logic        irq;
    logic        chip_reset_req;
    int          n_errors = 0;
    int          n_checks = 0;
    int          seed     = 32'h2085;

    wgt_windowed_guard_timer u_dut (
        .mclk(mclk), .resetn(resetn), .porn(porn), .guard_tick_clock(gclk), .cfg(cfg),
        .enable_set(pls[0]), .feed_wr(feed_wr), .feed_data(feed_data), .other_access(pls[1]),
        .tout_clr(pls[2]), .warn_clr(pls[3]), .wdrst_clr(pls[4]), .stat(stat), .irq(irq),
        .chip_reset_req(chip_reset_req)
    );

    // System clock at 100 MHz and a guard tick clock eight times slower, unrelated in phase.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #13 gclk = 1'b0;
        forever #40 gclk = ~gclk;
    end

    // Reload value after the design clamps it: never below the 256-step minimum.
    function automatic logic [23:0] exp_reload(input logic [23:0] t);
        return (t < WGT_TC_MIN) ? WGT_TC_MIN : t;
    endfunction

    // Compares one value, counts it and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle pulse on a control input, launched and dropped at falling edges.
    task automatic pulse(input int b);
        @(negedge mclk) pls[b] = 1'b1;
        @(negedge mclk) pls[b] = 1'b0;
    endtask

    // One write to the feed location.
    task automatic feed(input logic [7:0] d);
        @(negedge mclk);
        feed_wr = 1'b1;
        feed_data = d;
        @(negedge mclk) feed_wr = 1'b0;
    endtask

    // Chip reset as the reset request would cause it; power-on stays released.
    task automatic do_reset();
        @(negedge mclk) resetn = 1'b0;
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
    endtask

    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Cuts a hang short well after the expected run of about ten thousand cycles.
    initial begin
        #500000;
        n_errors++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        int          n;
        logic [23:0] t;
        logic [7:0]  d;
        {resetn, porn, feed_wr, feed_data, pls} = '0;
        cfg = '0;
        cfg.window = 24'hffffff;
        repeat (3) @(negedge mclk);
        {resetn, porn} = 2'b11;
        @(negedge mclk);
        check({stat.enabled, stat.tout_flag, stat.warn_flag, stat.wdrst_flag, irq, chip_reset_req}, 0);
        check(stat.count, 24'hffffff);
        // Short time-out is clamped, then expires into a chip reset after 256 steps of 4 ticks.
        cfg.reset_en = 1'b1;
        cfg.timeout = 24'h000010;
        pulse(0);
        check({stat.enabled, stat.count}, {1'b1, exp_reload(cfg.timeout)});
        for (n = 0; n < 9000 && chip_reset_req !== 1'b1; n++) @(negedge mclk);
        check(n >= 8176 && n <= 8208, 1);
        @(negedge mclk);
        check({stat.wdrst_flag, stat.enabled}, 2'b10);
        do_reset();
        check({stat.wdrst_flag, stat.enabled, chip_reset_req}, 3'b100);
        pulse(4);
        check(stat.wdrst_flag, 0);
        // Good feeds with random reload values and gaps.
        cfg.reset_en = 1'b0;
        cfg.int_en = 1'b1;
        pulse(0);
        for (n = 0; n < 8; n++) begin
            t = (n == 0) ? 24'h000000 : 24'($random(seed)) & 24'h0001ff;
            cfg.timeout = t;
            repeat ($random(seed) & 7) @(negedge mclk);
            feed(WGT_FEED_KEY1);
            feed(WGT_FEED_KEY2);
            @(negedge mclk);
            check({stat.tout_flag, stat.enabled, stat.count}, {2'b01, exp_reload(t)});
        end
        // Bad sequences: lone key two, wrong second key, other access, and one with reset on.
        for (n = 0; n < 4; n++) begin
            cfg.reset_en = (n == 3);
            pulse(0);
            d = 8'($random(seed)) | 8'h80;
            if (n == 0) feed(WGT_FEED_KEY2);
            else begin
                feed(WGT_FEED_KEY1);
                if (n == 2) pulse(1);
                else feed(d);
            end
            @(negedge mclk);
            check({stat.enabled, stat.tout_flag, irq, chip_reset_req, stat.wdrst_flag}, (n == 3) ? 5'b00011 : 5'b01100);
            if (n == 3) do_reset();
            pulse(2);
            pulse(4);
            check({stat.tout_flag, stat.wdrst_flag}, 0);
        end
        // Feed above the window is refused; at the window count it is taken.
        cfg.reset_en = 1'b0;
        cfg.timeout = 24'h000100;
        cfg.window = 24'h0000fe;
        pulse(0);
        feed(WGT_FEED_KEY1);
        feed(WGT_FEED_KEY2);
        @(negedge mclk);
        check({stat.tout_flag, stat.enabled}, 2'b10);
        pulse(2);
        pulse(0);
        for (n = 0; n < 200 && stat.count !== 24'h0000fe; n++) @(negedge mclk);
        feed(WGT_FEED_KEY1);
        feed(WGT_FEED_KEY2);
        @(negedge mclk);
        check({stat.tout_flag, stat.count}, {1'b0, 24'h000100});
        // Warning rises at its point and drives the interrupt until cleared.
        cfg.window = 24'hffffff;
        cfg.warn_en = 1'b1;
        cfg.warn = 24'h0000fd;
        for (n = 0; n < 200 && stat.warn_flag !== 1'b1; n++) @(negedge mclk);
        check({stat.warn_flag, irq, stat.count}, {2'b11, 24'h0000fd});
        pulse(3);
        check({stat.warn_flag, irq}, 2'b00);
        give_verdict();
    end
endmodule
